// *** rtl/configurable_logic_cell_gating.sv ***
// What this block does
// - data3 source picked by select bits 6:0
// - data4 source picked by select at 0x0691
// - gate1 odd bits admit true data lines
// - gate1 even bits admit inverted data lines
// - gate2 at 0x0693, same arrangement
// - gate3 at 0x0694, same arrangement
// - gate4 at 0x0695, same arrangement
// - gate enables undefined at power-on, kept otherwise
// - mirror bits 0-3 show cell outputs, reset 0
// - output polarity bit 7 inverts cell output
// - gate polarity bits 0-3 invert gate outputs
// - rising/falling enables set cell interrupt flag
`timescale 1ns/1ps
`include "cell_gating_map.svh"
module configurable_logic_cell_gating
   import cell_gating_pkg::*;
#(
   parameter int NUM_CELLS = 4,     // cells in the bank
   parameter int SRC_W     = 128    // source lines
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // register port
   input  wire logic [11:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // data sources
   input  wire logic [SRC_W-1:0]  sources,
   // results
   output logic      [3:0]        cell_output_level,
   output logic                   irq
);

   // per-cell configuration; selectors and gate enables carry no reset
   logic [7:0] control_q   [4];     // enable, irq enables, mode
   logic [3:0] gate_inv_q  [4];     // gate invert bits
   logic       out_inv_q   [4];     // output invert
   logic [6:0] dsel_q      [4][4];  // data source selectors per cell
   logic [7:0] gate_en_q   [4][4];  // term enables per cell and gate
   logic [3:0] instance_select_q;   // cell addressed by shared window
   logic [3:0] cell_q;              // registered cell outputs
   logic [3:0] cell_prev_q;         // for edge detect
   logic [3:0] state_q;             // sequential cell storage
   logic [3:0] cell_irq_flag_q;     // sticky status
   logic [3:0] irq_mask_q;          // interrupt mask
   logic [1:0] cur;                 // addressed cell index
   logic [3:0] logic_out;           // combinational cell outputs
   logic [3:0] state_d;             // next storage value

   assign cur = instance_select_q[1:0];

   // instance select register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         instance_select_q <= 4'h0;
      end else if (reg_wr && reg_addr == `OFS_INSTANCE_SEL) begin
         instance_select_q <= reg_wdata[3:0];
      end
   end

   // control and polarity of the addressed cell
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int c = 0; c < 4; c++) begin
            control_q[c] <= `RST_CONTROL;
            out_inv_q[c] <= `RST_OUT_INVERT;
         end
      end else if (reg_wr && instance_select_q < 4'h4) begin
         if (reg_addr == `OFS_CELL_CONTROL) begin
            control_q[cur] <= reg_wdata;
         end
         if (reg_addr == `OFS_CELL_POLARITY) begin
            out_inv_q[cur] <= reg_wdata[`POL_OUT_INVERT_BIT];
         end
      end
   end

   // gate invert, selectors and term enables: not touched by reset
   always_ff @(posedge clk_sys) begin
      if (reg_wr && instance_select_q < 4'h4) begin
         if (reg_addr == `OFS_CELL_POLARITY) begin
            gate_inv_q[cur] <= reg_wdata[3:0];
         end
         // data source selectors
         for (int s = 0; s < 4; s++) begin
            if (reg_addr == `OFS_DATA1_SEL + 12'(s)) begin
               dsel_q[cur][s] <= reg_wdata[6:0];
            end
         end
         // gate term enables
         for (int g = 0; g < 4; g++) begin
            if (reg_addr == `OFS_GATE1_EN + 12'(g)) begin
               gate_en_q[cur][g] <= reg_wdata;
            end
         end
      end
   end

   // gate logic and cell function
   always_comb begin
      logic [3:0] d;
      logic [3:0] gt;
      logic [7:0] terms;
      d = 4'h0;
      gt = 4'h0;
      terms = 8'h00;
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 4; s++) begin
            d[s] = sources[dsel_q[c][s]];
         end
         for (int g = 0; g < 4; g++) begin
            for (int y = 0; y < 4; y++) begin
               terms[2*y+1] = gate_en_q[c][g][2*y+1] & d[y];
               terms[2*y]   = gate_en_q[c][g][2*y] & ~d[y];
            end
            gt[g] = (|terms) ^ gate_inv_q[c][g];
         end
         // modes 4-6 treat gate1 as a per-cycle load enable, mode 7 loads while gate1 is low
         state_d[c] = state_q[c];
         case (cell_mode_t'(control_q[c][2:0]))
            MODE_AND_OR:   logic_out[c] = (gt[0] & gt[1]) | (gt[2] & gt[3]);
            MODE_OR_XOR:   logic_out[c] = (gt[0] | gt[1]) ^ (gt[2] | gt[3]);
            MODE_AND4:     logic_out[c] = &gt;
            MODE_SR_LATCH: begin
               if (gt[2] | gt[3]) state_d[c] = 1'b0;
               else if (gt[0] | gt[1]) state_d[c] = 1'b1;
               logic_out[c] = state_q[c];
            end
            MODE_DFF_SR: begin
               if (gt[2]) state_d[c] = 1'b0;
               else if (gt[3]) state_d[c] = 1'b1;
               else if (gt[0]) state_d[c] = gt[1];
               logic_out[c] = state_q[c];
            end
            MODE_DFF2_R: begin
               if (gt[2]) state_d[c] = 1'b0;
               else if (gt[0]) state_d[c] = gt[1] & gt[3];
               logic_out[c] = state_q[c];
            end
            MODE_JK_R: begin
               if (gt[2]) state_d[c] = 1'b0;
               else if (gt[0]) state_d[c] = (gt[1] & ~state_q[c]) | (~gt[3] & state_q[c]);
               logic_out[c] = state_q[c];
            end
            MODE_LATCH_SR: begin
               if (gt[2]) state_d[c] = 1'b0;
               else if (gt[3]) state_d[c] = 1'b1;
               else if (~gt[0]) state_d[c] = gt[1];
               logic_out[c] = state_d[c];
            end
            default:       logic_out[c] = 1'b0;
         endcase
         logic_out[c] = logic_out[c] ^ out_inv_q[c];
      end
   end

   // cell storage and output registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q     <= 4'h0;
         cell_q      <= `RST_MIRROR;
         cell_prev_q <= `RST_MIRROR;
      end else begin
         state_q     <= state_d;
         cell_prev_q <= cell_q;
         for (int c = 0; c < 4; c++) begin
            // a disabled cell drives low
            cell_q[c] <= control_q[c][`CTL_ENABLE_BIT] & logic_out[c];
         end
      end
   end

   // sticky interrupt flags, edge set wins over write-one clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cell_irq_flag_q <= `RST_IRQ;
         irq_mask_q      <= `RST_IRQ;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if ((control_q[c][`CTL_RISE_IRQ_BIT] & cell_q[c] & ~cell_prev_q[c]) |
                (control_q[c][`CTL_FALL_IRQ_BIT] & ~cell_q[c] & cell_prev_q[c])) begin
               cell_irq_flag_q[c] <= 1'b1;
            end else if (reg_wr && reg_addr == `OFS_IRQ_STATUS && reg_wdata[c]) begin
               cell_irq_flag_q[c] <= 1'b0;
            end
         end
         if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[3:0];
         end
      end
   end

   // level interrupt output
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(cell_irq_flag_q & irq_mask_q);
      end
   end

   // mirrored output pins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cell_output_level <= `RST_MIRROR;
      end else begin
         cell_output_level <= cell_q;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= 8'h00;
         if (instance_select_q < 4'h4) begin
            case (reg_addr)
               `OFS_CELL_CONTROL:  reg_rdata <= {control_q[cur][7], 1'b0, cell_q[cur],
                                                 control_q[cur][4:0]};
               `OFS_CELL_POLARITY: reg_rdata <= {out_inv_q[cur], 3'h0, gate_inv_q[cur]};
               `OFS_DATA1_SEL:     reg_rdata <= {1'b0, dsel_q[cur][0]};
               `OFS_DATA2_SEL:     reg_rdata <= {1'b0, dsel_q[cur][1]};
               `OFS_DATA3_SEL:     reg_rdata <= {1'b0, dsel_q[cur][2]};
               `OFS_DATA4_SEL:     reg_rdata <= {1'b0, dsel_q[cur][3]};
               `OFS_GATE1_EN:      reg_rdata <= gate_en_q[cur][0];
               `OFS_GATE2_EN:      reg_rdata <= gate_en_q[cur][1];
               `OFS_GATE3_EN:      reg_rdata <= gate_en_q[cur][2];
               `OFS_GATE4_EN:      reg_rdata <= gate_en_q[cur][3];
               default:            reg_rdata <= 8'h00;
            endcase
         end
         case (reg_addr)
            `OFS_INSTANCE_SEL:  reg_rdata <= {4'h0, instance_select_q};
            `OFS_OUTPUT_MIRROR: reg_rdata <= {4'h0, cell_q};
            `OFS_IRQ_STATUS:    reg_rdata <= {4'h0, cell_irq_flag_q};
            `OFS_IRQ_MASK:      reg_rdata <= {4'h0, irq_mask_q};
            default:            ;
         endcase
      end
   end

endmodule

// *** pkg/cell_gating_map.svh ***
`ifndef CELL_GATING_MAP_SVH
`define CELL_GATING_MAP_SVH
// register offsets
`define OFS_CELL_CONTROL     12'h68c
`define OFS_CELL_POLARITY    12'h68d
`define OFS_DATA1_SEL        12'h68e
`define OFS_DATA2_SEL        12'h68f
`define OFS_DATA3_SEL        12'h690
`define OFS_DATA4_SEL        12'h691
`define OFS_GATE1_EN         12'h692
`define OFS_GATE2_EN         12'h693
`define OFS_GATE3_EN         12'h694
`define OFS_GATE4_EN         12'h695
`define OFS_INSTANCE_SEL     12'h696
`define OFS_OUTPUT_MIRROR    12'h697
`define OFS_IRQ_STATUS       12'h698
`define OFS_IRQ_MASK         12'h699
// control fields
`define CTL_ENABLE_BIT       7
`define CTL_OUT_BIT          5
`define CTL_RISE_IRQ_BIT     4
`define CTL_FALL_IRQ_BIT     3
// polarity fields
`define POL_OUT_INVERT_BIT   7
// reset values
`define RST_CONTROL          8'h00
`define RST_OUT_INVERT       1'b0
`define RST_MIRROR           4'h0
`define RST_IRQ              4'h0
`endif

// *** pkg/cell_gating_pkg.sv ***
package cell_gating_pkg;
   // cell function codes
   typedef enum logic [2:0] {
      MODE_AND_OR, MODE_OR_XOR, MODE_AND4, MODE_SR_LATCH,
      MODE_DFF_SR, MODE_DFF2_R, MODE_JK_R, MODE_LATCH_SR
   } cell_mode_t;
endpackage

// *** dv/cell_gating_sva.sv ***
`timescale 1ns/1ps
// port-level checks of the cell bank register window and pins
module cell_gating_sva (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [3:0]  cell_output_level,
   input wire logic        irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [3:0] sel_q; // instance select as last written
   // track the select so per-cell checks know their target
   always_ff @(posedge clk_sys)
      if (reset)
         sel_q <= 4'h0;
      else if (reg_wr && reg_addr == 12'h696)
         sel_q <= reg_wdata[3:0];
   // a write then a read of the same place gives back the stored bits
   property p_back(logic [11:0] lo, logic [11:0] hi, logic [7:0] m);
      reg_wr && reg_addr >= lo && reg_addr <= hi && sel_q < 4'h4 ##1
         reg_rd && reg_addr == $past(reg_addr)
         |=> ((reg_rdata ^ $past(reg_wdata, 2)) & m) == 8'h00;
   endproperty
   a_data3_back: assert property (p_back(12'h690, 12'h690, 8'h7f))
      else $error("data3 select readback wrong");
   a_data4_back: assert property (p_back(12'h691, 12'h691, 8'h7f))
      else $error("data4 select readback wrong");
   a_gate_back: assert property (p_back(12'h692, 12'h695, 8'hff))
      else $error("gate enable readback wrong");
   a_mirror_pins: assert property (reg_rd && reg_addr == 12'h697
      |=> reg_rdata[3:0] == cell_output_level) else $error("mirror differs from pins");
   a_reset_clear: assert property ($past(reset) |-> cell_output_level == 4'h0 && !irq)
      else $error("outputs not cleared by reset");
   a_empty_slot: assert property (reg_rd && reg_addr inside {[12'h68c:12'h695]} && sel_q > 4'h3
      |=> reg_rdata == 8'h00) else $error("empty cell slot read not zero");
   a_unmapped: assert property (reg_rd && !(reg_addr inside {[12'h68c:12'h699]})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_mask_quiet: assert property (reg_wr && reg_addr == 12'h699 && reg_wdata[3:0] == 4'h0
      ##1 !(reg_wr && reg_addr == 12'h699) |=> !irq) else $error("masked interrupt raised");
   c_irq: cover property (irq);
   c_empty: cover property (reg_rd && sel_q > 4'h3);
   c_rise: cover property ($rose(cell_output_level[0]));
endmodule

bind configurable_logic_cell_gating cell_gating_sva u_sva (.clk_sys, .reset, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cell_output_level, .irq);

// *** dv/test_configurable_logic_cell_gating.sv ***
`timescale 1ns/1ps
// directed bench for the cell bank register window and cell pins
module test_configurable_logic_cell_gating;
   logic         clk_sys = 1'b0;  // system clock
   logic         reset = 1'b1;    // synchronous reset
   logic [11:0]  reg_addr = 12'h000;
   logic [7:0]   reg_wdata = 8'h00;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [127:0] sources = '0;    // data source lines
   logic [7:0]   reg_rdata;
   logic [3:0]   cell_output_level;
   logic         irq;
   int           bad_count = 0;
   int           samples_checked = 0;

   configurable_logic_cell_gating dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .sources, .cell_output_level, .irq);

   initial forever #25 clk_sys = ~clk_sys;

   task automatic complete_run;
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string w, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(logic [11:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // one-cycle read, data judged in the following cycle
   task automatic rdc(string w, logic [11:0] a, logic [7:0] e, logic [7:0] m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(w, e, reg_rdata & m);
   endtask
   // let a change reach the pins, then judge cell 0 output or the interrupt
   task automatic pinc(logic e, logic on_irq);
      repeat (6) @(posedge clk_sys);
      #1;
      chk("pin", {7'h0, e}, {7'h0, on_irq ? irq : cell_output_level[0]});
   endtask
   // reset values, steering, empty slot, retention through reset
   task automatic s_regs;
      logic [7:0] v;
      rdc("mirror", 12'h697, 8'h00, 8'h0f);
      rdc("polarity", 12'h68d, 8'h00, 8'h80);
      rdc("unmapped", 12'h68b, 8'h00, 8'hff);
      for (int c = 0; c < 5; c++) begin
         wr(12'h696, 8'(c));
         for (int i = 0; i < 4; i++) begin
            v = 8'(c * 16 + i + 1);
            wr(12'h68e + 12'(i), v);
            rdc("select", 12'h68e + 12'(i), c < 4 ? v : 8'h00, 8'h7f);
            v = 8'(c * 37 + i * 11 + 3);
            wr(12'h692 + 12'(i), v);
            rdc("gate", 12'h692 + 12'(i), c < 4 ? v : 8'h00, 8'hff);
         end
      end
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      rdc("kept gate", 12'h692, 8'h03, 8'hff);
      rdc("kept select", 12'h68e, 8'h01, 8'h7f);
   endtask
   // every gate, every data line, true and inverted, then polarity
   task automatic s_gates;
      wr(12'h68d, 8'h00);
      wr(12'h68c, 8'h81);
      for (int y = 0; y < 4; y++)
         wr(12'h68e + 12'(y), 8'(10 + 30 * y));
      for (int k = 0; k < 4; k++)
         for (int y = 0; y < 4; y++) begin
            for (int j = 0; j < 4; j++)
               wr(12'h692 + 12'(j), 8'h00);
            for (int t = 0; t < 2; t++) begin
               wr(12'h692 + 12'(k), (8'h02 >> t) << (2 * y));
               for (int n = 0; n < 2; n++) begin
                  sources <= 128'(n) << (10 + 30 * y);
                  pinc(n[0] ^ t[0], 1'b0);
               end
            end
         end
      wr(12'h695, 8'h00);
      pinc(1'b0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(12'h68d, 8'h01 << k);
         pinc(1'b1, 1'b0);
      end
      wr(12'h68d, 8'h80);
      pinc(1'b1, 1'b0);
      rdc("mirror", 12'h697, 8'h01, 8'h0f);
      wr(12'h68d, 8'h81);
      pinc(1'b0, 1'b0);
   endtask
   // combinational modes with gates forced by their invert bits
   task automatic s_modes;
      for (int m = 0; m < 3; m++)
         for (int p = 0; p < 2; p++) begin
            wr(12'h68c, 8'h80 | 8'(m));
            wr(12'h68d, p ? 8'h0f : 8'h01);
            pinc(p[0] ^ (m == 1), 1'b0);
         end
      // storage modes: drive the stored bit high, then clear it with gate3
      for (int m = 3; m < 8; m++) begin
         wr(12'h68c, 8'h80 | 8'(m));
         case (m)
            3:       wr(12'h68d, 8'h01);
            5:       wr(12'h68d, 8'h0b);
            6:       wr(12'h68d, 8'h03);
            default: wr(12'h68d, 8'h08);
         endcase
         pinc(1'b1, 1'b0);
         wr(12'h68d, 8'h04);
         pinc(1'b0, 1'b0);
      end
   endtask
   // rising and falling edge flags, mask and clear
   task automatic s_irq;
      wr(12'h68c, 8'h91);
      wr(12'h68d, 8'h00);
      wr(12'h699, 8'h01);
      wr(12'h698, 8'h0f);
      pinc(1'b0, 1'b1);
      wr(12'h68d, 8'h80);
      pinc(1'b1, 1'b1);
      rdc("status", 12'h698, 8'h01, 8'h0f);
      wr(12'h699, 8'h00);
      pinc(1'b0, 1'b1);
      wr(12'h699, 8'h01);
      pinc(1'b1, 1'b1);
      wr(12'h698, 8'h01);
      pinc(1'b0, 1'b1);
      wr(12'h68c, 8'h89);
      wr(12'h68d, 8'h00);
      pinc(1'b1, 1'b1);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      s_regs;
      s_gates;
      s_modes;
      s_irq;
      complete_run;
   end
   // hang guard, far beyond the expected run length
   initial begin
      #500000;
      bad_count++;
      complete_run;
   end
endmodule
